// [rtl/boot_cmd_regs.vh]
// Constants of the serial boot command responder: protocol codes, flash
// layout and the fixed product information image.
// Assumes inclusion by bare name from the rtl folder.
`ifndef BOOT_CMD_REGS_VH
`define BOOT_CMD_REGS_VH

// First byte: serial operating mode, echoed as the mode acknowledge
`define MODE_ASYNC      8'h86
`define MODE_CLOCKED    8'h30

// Command codes and their acknowledges
`define CMD_SUM         8'h20
`define CMD_INFO        8'h30
`define ACK_SUM         8'h20
`define ACK_INFO        8'h10
`define NACK_LOW        4'h1
`define COMM_ERROR      8'h08

// Flash array
`define FLASH_AW        19
`define FLASH_BYTES     524288
`define FLASH_FIRST     19'h00000
`define INFO_ADDR       19'h00470
`define INFO_SPAN       19'h00003

// Reply byte indices, counted from the fifth byte of the sequence
`define SUM_HI_IDX      6'd0
`define SUM_LO_IDX      6'd1
`define SUM_LAST_IDX    6'd2
`define INFO_FLASH_CNT  6'd4
`define INFO_LAST_IDX   6'd61
`define INFO_TBL_TOP    6'd60
`define ZERO_BYTE       8'h00

// Product name, twelve ASCII characters; the value is arbitrary
`define PRODUCT_NAME    96'h424f4f54444556494345_3031
// Memory configuration bytes sent as reply bytes 21 to 65
`define INFO_TABLE      360'h74040000_0080ffff_ff8fffff_ffdfffff_0090ffff_ffcfffff_0000_00000000_ffff0700_0000_00000000_00000100_04

`endif

// [rtl/byte_accumulator.v]
// Running modular sum of bytes, used for the flash sum and reply checksums.
// Assumes one clock domain; clear wins over add.
`timescale 1ns/1ps
`default_nettype none

module byte_accumulator #(
	parameter W = 16
) (
	// Clock and reset
	input  wire         clk,
	input  wire         reset_n,
	// Control
	input  wire         clear,
	input  wire         add,
	input  wire [W-1:0] data,
	// Result
	output reg  [W-1:0] sum
);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			sum <= {W{1'b0}};
		else if (clear)
			sum <= {W{1'b0}};
		else if (add)
			sum <= sum + data;
	end

endmodule

`default_nettype wire

// [rtl/serial_boot_command_responder.v]
// Serial boot command responder: mode handshake, command decode, flash sum
// and product information replies, at byte level.
// Assumes a same-clock serial engine delivering rx bytes and taking tx bytes,
// and a synchronous flash read port with one cycle of latency.
`timescale 1ns/1ps
`default_nettype none
`include "boot_cmd_regs.vh"

// Overview of operation
// - Device echoes the accepted mode code as the second byte.
// - Async mode without usable baud rate aborts the session, no acknowledge.
// - After any negative acknowledge, wait again for a command code.
// - Clocked mode sends no code on a communication error.
// - Sum query 20H; answer 20H accept, x1H reject, x8H error.
// - Sum reply: upper byte, lower byte, then checksum of both.
// - After a full reply, wait for the next command code.
// - Information query 30H; answer 10H accept, x1H reject, x8H error.
// - Info bytes five to eight: four flash bytes, ascending addresses.
// - Info bytes nine to twenty: fixed twelve-character ASCII name.
// - Flash sum adds every byte of the whole flash array.
// - Info reply ends with checksum over bytes five to sixty-five.
module serial_boot_command_responder #(
	parameter FLASH_BYTES = `FLASH_BYTES
) (
	// Clock and reset
	input  wire                  clk,
	input  wire                  reset_n,
	// Received bytes from the serial engine
	input  wire                  rx_valid,
	input  wire [7:0]            rx_data,
	input  wire                  rx_error,
	input  wire                  baud_ok,
	// Bytes to the serial engine
	output reg                   tx_valid,
	output reg  [7:0]            tx_data,
	input  wire                  tx_ready,
	// Flash read port
	output reg  [`FLASH_AW-1:0]  flash_addr,
	output reg                   flash_rd,
	input  wire [7:0]            flash_rdata,
	// Session status
	output reg                   clocked_mode,
	output reg                   full_rate,
	output reg                   boot_abort
);

	localparam [2:0] S_MODE  = 3'd0;
	localparam [2:0] S_CMD   = 3'd1;
	localparam [2:0] S_ACK   = 3'd2;
	localparam [2:0] S_SCAN  = 3'd3;
	localparam [2:0] S_REPLY = 3'd4;
	localparam [2:0] S_ABORT = 3'd5;

	localparam [31:0] SUM_LAST32 = FLASH_BYTES - 1;
	localparam [`FLASH_AW-1:0] SUM_LAST = SUM_LAST32[`FLASH_AW-1:0];

	reg  [2:0]            state;
	reg  [2:0]            after_ack;
	reg                   is_info;
	reg  [5:0]            idx;
	reg  [31:0]           info_buf;
	reg                   rd_valid;
	reg  [`FLASH_AW-1:0]  scan_last;
	reg  [7:0]            reply_byte;

	wire [15:0]           flash_sum;
	wire [7:0]            tx_sum;
	wire [455:0]          info_image = {`PRODUCT_NAME, `INFO_TABLE};
	wire [5:0]            tbl_rev = `INFO_TBL_TOP - idx;
	wire [7:0]            tbl_byte = info_image[{tbl_rev, 3'b000} +: 8];
	wire [7:0]            cks_byte = `ZERO_BYTE - tx_sum;
	wire [5:0]            last_idx = is_info ? `INFO_LAST_IDX : `SUM_LAST_IDX;
	wire                  tx_load = (state == S_REPLY) && !tx_valid;
	wire                  tx_done = tx_valid && tx_ready;

	// Flash sum wraps at 16 bits; the low 16 bits of the total are reported, upper byte first
	byte_accumulator #(
		.W       (16)
	) u_flash_sum (
		.clk     (clk),
		.reset_n (reset_n),
		.clear   (state == S_ACK),
		.add     (rd_valid && !is_info),
		.data    ({`ZERO_BYTE, flash_rdata}),
		.sum     (flash_sum)
	);

	// Checksum over the reply bytes, cleared before the first one is loaded
	byte_accumulator #(
		.W       (8)
	) u_tx_sum (
		.clk     (clk),
		.reset_n (reset_n),
		.clear   (state == S_SCAN),
		.add     (tx_load),
		.data    (reply_byte),
		.sum     (tx_sum)
	);

	always @* begin
		reply_byte = cks_byte;
		if (is_info) begin
			if (idx < `INFO_FLASH_CNT)
				reply_byte = info_buf[31:24];
			else if (idx < `INFO_LAST_IDX)
				reply_byte = tbl_byte;
		end else if (idx == `SUM_HI_IDX) begin
			reply_byte = flash_sum[15:8];
		end else if (idx == `SUM_LO_IDX) begin
			reply_byte = flash_sum[7:0];
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state        <= S_MODE;
			after_ack    <= S_CMD;
			is_info      <= 1'b0;
			idx          <= 6'd0;
			info_buf     <= 32'h0000_0000;
			rd_valid     <= 1'b0;
			scan_last    <= `FLASH_FIRST;
			tx_valid     <= 1'b0;
			tx_data      <= `ZERO_BYTE;
			flash_addr   <= `FLASH_FIRST;
			flash_rd     <= 1'b0;
			clocked_mode <= 1'b0;
			full_rate    <= 1'b0;
			boot_abort   <= 1'b0;
		end else begin
			rd_valid <= flash_rd;
			case (state)
			S_MODE: begin
				// A byte that is neither mode code is ignored
				if (rx_valid && !rx_error) begin
					if (rx_data == `MODE_ASYNC) begin
						if (baud_ok) begin
							tx_data   <= `MODE_ASYNC;
							tx_valid  <= 1'b1;
							after_ack <= S_CMD;
							state     <= S_ACK;
						end else begin
							boot_abort <= 1'b1;
							state      <= S_ABORT;
						end
					end else if (rx_data == `MODE_CLOCKED) begin
						clocked_mode <= 1'b1;
						tx_data      <= `MODE_CLOCKED;
						tx_valid     <= 1'b1;
						after_ack    <= S_CMD;
						state        <= S_ACK;
					end
				end
			end
			S_CMD: begin
				if (rx_valid) begin
					if (rx_error) begin
						if (!clocked_mode) begin
							tx_data   <= `COMM_ERROR;
							tx_valid  <= 1'b1;
							after_ack <= S_CMD;
							state     <= S_ACK;
						end
						// Clocked mode stays silent and keeps waiting
					end else if (rx_data == `CMD_SUM) begin
						tx_data   <= `ACK_SUM;
						tx_valid  <= 1'b1;
						is_info   <= 1'b0;
						after_ack <= S_SCAN;
						state     <= S_ACK;
					end else if (rx_data == `CMD_INFO) begin
						tx_data   <= `ACK_INFO;
						tx_valid  <= 1'b1;
						is_info   <= 1'b1;
						after_ack <= S_SCAN;
						state     <= S_ACK;
					end else begin
						// RAM transfer is not served here, so it is rejected too
						tx_data   <= {rx_data[7:4], `NACK_LOW};
						tx_valid  <= 1'b1;
						after_ack <= S_CMD;
						state     <= S_ACK;
					end
				end
			end
			S_ACK: begin
				if (tx_done) begin
					tx_valid <= 1'b0;
					state    <= after_ack;
					if (clocked_mode)
						full_rate <= 1'b1;
					if (after_ack == S_SCAN) begin
						flash_rd <= 1'b1;
						if (is_info) begin
							flash_addr <= `INFO_ADDR;
							scan_last  <= `INFO_ADDR + `INFO_SPAN;
						end else begin
							flash_addr <= `FLASH_FIRST;
							scan_last  <= SUM_LAST;
						end
					end
				end
			end
			S_SCAN: begin
				if (flash_rd) begin
					if (flash_addr == scan_last)
						flash_rd <= 1'b0;
					else
						flash_addr <= flash_addr + 1'b1;
				end
				if (rd_valid && is_info)
					info_buf <= {info_buf[23:0], flash_rdata};
				if (!flash_rd && !rd_valid) begin
					idx   <= 6'd0;
					state <= S_REPLY;
				end
			end
			S_REPLY: begin
				if (tx_done) begin
					tx_valid <= 1'b0;
					if (idx == last_idx)
						state <= S_CMD;
					else
						idx <= idx + 1'b1;
				end else if (tx_load) begin
					tx_data  <= reply_byte;
					tx_valid <= 1'b1;
					if (is_info && idx < `INFO_FLASH_CNT)
						info_buf <= {info_buf[23:0], `ZERO_BYTE};
				end
			end
			S_ABORT: begin
				// Session is dead until the next reset
				state <= S_ABORT;
			end
			default: begin
				state <= S_MODE;
			end
			endcase
		end
	end

endmodule

`default_nettype wire

// [verification/boot_cmd_checker_assertions.sv]
// Checker on the responder ports.
// Bound to the top module at the foot.
`timescale 1ns/1ps
`default_nettype none
module boot_cmd_checker (
	// Clock
	input wire logic       clk,
	input wire logic       reset_n,
	// Link
	input wire logic       rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic       rx_error,
	input wire logic       baud_ok,
	input wire logic       tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic       tx_ready,
	// Status
	input wire logic       clocked_mode,
	input wire logic       boot_abort
);
	logic       opened;
	logic [2:0] quiet;
	logic [7:0] last_rx;
	// Command wait is inferred from silence, so bytes sent mid-reply are not judged
	wire        cmd = opened && quiet > 3'h3 && rx_valid;
	wire        ok = cmd && !rx_error;
	wire        mode = !opened && rx_valid;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			opened  <= 1'h0;
			quiet   <= 3'h0;
			last_rx <= 8'h00;
		end else begin
			opened  <= opened | tx_valid;
			quiet   <= tx_valid ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
			last_rx <= rx_data;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
	a_hold: assert property (p_hold) else $error("tx byte not held");
	property p_m86; mode && rx_data == 8'h86 && baud_ok |=> tx_valid && tx_data == 8'h86; endproperty
	a_m86: assert property (p_m86) else $error("no async mode echo");
	property p_m30; mode && !rx_error && rx_data == 8'h30 |=> tx_valid && tx_data == 8'h30; endproperty
	a_m30: assert property (p_m30) else $error("no clocked mode echo");
	property p_abort; mode && rx_data == 8'h86 && !baud_ok |=> boot_abort && !tx_valid; endproperty
	a_abort: assert property (p_abort) else $error("no abort");
	property p_cerr; cmd && rx_error && clocked_mode |=> !tx_valid [*4]; endproperty
	a_cerr: assert property (p_cerr) else $error("code sent on clocked error");
	property p_aerr; cmd && rx_error && !clocked_mode |=> tx_valid && tx_data == 8'h08; endproperty
	a_aerr: assert property (p_aerr) else $error("no error code");
	property p_sum; ok && rx_data == 8'h20 |=> tx_valid && tx_data == 8'h20; endproperty
	a_sum: assert property (p_sum) else $error("no sum ack");
	property p_info; ok && rx_data == 8'h30 |=> tx_valid && tx_data == 8'h10; endproperty
	a_info: assert property (p_info) else $error("no info ack");
	property p_nack;
		ok && rx_data != 8'h20 && rx_data != 8'h30 |=> tx_valid && tx_data == {last_rx[7:4], 4'h1};
	endproperty
	a_nack: assert property (p_nack) else $error("bad nack");
	c_sum: cover property (ok && rx_data == 8'h20);
	c_cerr: cover property (cmd && rx_error && clocked_mode);
	c_abort: cover property (mode && !baud_ok);
	c_info: cover property (ok && rx_data == 8'h30);
endmodule
bind serial_boot_command_responder boot_cmd_checker u_boot_cmd_checker (
	.clk(clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data),
	.rx_error(rx_error), .baud_ok(baud_ok), .tx_valid(tx_valid), .tx_data(tx_data),
	.tx_ready(tx_ready), .clocked_mode(clocked_mode), .boot_abort(boot_abort));
`default_nettype wire

// [verification/host_link_model.sv]
// Host side of the byte link: takes reply bytes with stalls.
// The bench reads and empties the collected queue.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	// Clock
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Bytes from the device
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output wire logic       tx_ready
);
	logic [2:0] phase;
	logic [7:0] got[$];
	// Two stall cycles in eight give both prompt and slow acceptance
	assign tx_ready = phase != 3'h2 && phase != 3'h5;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase <= 3'h0;
		end else begin
			phase <= phase + 3'h1;
			if (tx_valid && tx_ready)
				got.push_back(tx_data);
		end
	end
endmodule
`default_nettype wire

// [verification/test_serial_boot_command_responder.sv]
// Bench: random boot commands, replies checked byte by byte.
// Flash is modelled here; the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
`include "boot_cmd_regs.vh"
module test_serial_boot_command_responder;
	logic        clk = 1'h0, reset_n = 1'h0, rx_valid = 1'h0, rx_error = 1'h0;
	logic        baud_ok = 1'h1, cs = 1'h0;
	logic [7:0]  rx_data = 8'h00, flash_rdata = 8'h00, c;
	wire         tx_valid, tx_ready, flash_rd, clocked_mode, full_rate, boot_abort;
	wire  [7:0]  tx_data;
	wire  [18:0] flash_addr;
	logic [7:0]  mem [0:19];
	logic [7:0]  exp[$];
	logic [31:0] seed = 32'h1d;
	integer      miscompares = 0, checks = 0, i;
	always #5 clk = ~clk;
	serial_boot_command_responder #(.FLASH_BYTES(16)) u_serial_boot_command_responder (
		.clk(clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_error(rx_error), .baud_ok(baud_ok), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .flash_addr(flash_addr), .flash_rd(flash_rd),
		.flash_rdata(flash_rdata), .clocked_mode(clocked_mode), .full_rate(full_rate),
		.boot_abort(boot_abort));
	host_link_model u_host_link_model (.clk(clk), .reset_n(reset_n), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready));
	// Entries 16 to 19 stand for the four product information bytes; any other
	// address folds onto the low sixteen, so a wrong info address shows as wrong data
	always @(posedge clk)
		if (flash_rd)
			flash_rdata <= mem[flash_addr[18:2] == 17'h0011c ? {3'h4, flash_addr[1:0]}
				: {1'h0, flash_addr[3:0]}];
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic send(input logic [7:0] b, input logic e);
		@(posedge clk);
		#1 {rx_valid, rx_data, rx_error} = {1'h1, b, e};
		@(posedge clk);
		#1 {rx_valid, rx_error} = 2'h0;
	endtask
	task automatic plan(input logic [7:0] k, input logic e);
		logic [15:0] f;
		logic [7:0]  t;
		f = 16'h0000;
		t = 8'h00;
		exp = {};
		if (e && !cs)
			exp = {`COMM_ERROR};
		else if (!e && k == `CMD_SUM) begin
			for (i = 0; i < 16; i++)
				f += mem[i];
			exp = {`ACK_SUM, f[15:8], f[7:0]};
		end else if (!e && k == `CMD_INFO) begin
			exp = {`ACK_INFO, mem[16], mem[17], mem[18], mem[19]};
			for (i = 56; i >= 0; i--)
				exp.push_back(8'({`PRODUCT_NAME, `INFO_TABLE} >> 8 * i));
		end else if (!e)
			exp = {{k[7:4], 4'h1}};
		for (i = 1; i < exp.size(); i++)
			t += exp[i];
		if (exp.size() > 1)
			exp.push_back(8'h00 - t);
	endtask
	task automatic collect();
		for (i = 0; i < 999 && u_host_link_model.got.size() < exp.size(); i++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		check(u_host_link_model.got.size(), exp.size());
		foreach (exp[k])
			check(u_host_link_model.got[k], exp[k]);
		u_host_link_model.got = {};
		$display("test done, %0d bytes", exp.size());
	endtask
	task automatic run(input logic [7:0] k, input logic e);
		plan(k, e);
		send(k, e);
		collect();
	endtask
	task automatic open(input logic [7:0] m);
		exp = {};
		if (m == `MODE_ASYNC && baud_ok || m == `MODE_CLOCKED)
			exp = {m};
		send(m, 1'h0);
		collect();
	endtask
	task automatic cycle_reset();
		#1 reset_n = 1'h0;
		@(posedge clk);
		#1 reset_n = 1'h1;
	endtask
	initial begin
		for (i = 0; i < 20; i++)
			mem[i] = rnd();
		repeat (4) @(posedge clk);
		#1 reset_n = 1'h1;
		open(8'h55);
		open(`MODE_ASYNC);
		run(`CMD_SUM, 1'h0);
		run(`CMD_INFO, 1'h0);
		run(8'h10, 1'h0);
		run(`CMD_INFO, 1'h1);
		repeat (12) begin
			c = rnd();
			run(c[0] ? c : (c[1] ? `CMD_INFO : `CMD_SUM), c[2] & c[3]);
		end
		check(clocked_mode, 0);
		check(full_rate, 0);
		cycle_reset();
		cs = 1'h1;
		open(`MODE_CLOCKED);
		check(full_rate, 1);
		check(clocked_mode, 1);
		run(`CMD_INFO, 1'h1);
		run(`CMD_SUM, 1'h0);
		cycle_reset();
		baud_ok = 1'h0;
		open(`MODE_ASYNC);
		check(boot_abort, 1);
		open(`CMD_SUM);
		give_verdict();
	end
	initial begin
		#400000;
		miscompares++;
		give_verdict();
	end
endmodule
`default_nettype wire
